/* File: core/adc_result_control.sv */
// converter control: register file, accumulation, result packing, analog settings
// Behaviour
// - left adjust ignored in 8-bit single mode and in unscaled accumulation results; the sample register still applies it in accumulation modes
// - scaled mode, left adjust, count below 4: shift left by 4 minus count
// - differential results are two's complement, sign-extended through bit 31
// - 12-bit single with left adjust places conversion shifted left four
// - sample register formatted by mode, left adjust and differential selection
// - converter clock is core clock divided per divider select field
// - negative input used only for differential conversions
// - input and reference selections drive the analog side unbuffered
// - reference selected from field in third control register
// - gain amplifier offers 1x to 16x, usable in every mode
// - gain amplifier disabled after reset, inputs sampled directly
// - via-amplifier field shared between positive and negative input registers
// - amplifier bias select field held in amplifier control register
// - single-ended conversions clip to 0xfff above and 0x000 below range, before formatting
// - scaled accumulation with count 4 or more shifted right by count minus four after last sample
// - mode field encodes six operation modes 0 to 5
//
// The address-and-strobe port and the register addresses are this design's own decisions.
module adc_result_control (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    input wire adc_fmt_pkg::conv_in_type conv_in,
    output adc_fmt_pkg::analog_ctl_type analog_ctl,
    output logic continuous_run,
    output logic sample_ready,
    output logic result_ready,
    output logic clk_adc
);
    logic [2:0] div_sel_ff;
    logic [2:0] nxt_div_sel;
    logic [2:0] ref_sel_ff;
    logic [2:0] nxt_ref_sel;
    logic [7:0] timebase_ff;
    logic [7:0] nxt_timebase;
    logic [2:0] mode_ff;
    logic [2:0] nxt_mode;
    logic differential_sel_ff;
    logic nxt_differential_sel;
    logic [3:0] acc_sel_ff;
    logic [3:0] nxt_acc_sel;
    logic left_ff;
    logic nxt_left;
    logic run_ff;
    logic nxt_run;
    logic [5:0] pos_ff;
    logic [5:0] nxt_pos;
    logic [5:0] neg_ff;
    logic [5:0] nxt_neg;
    logic [1:0] via_ff;
    logic [1:0] nxt_via;
    logic amp_en_ff;
    logic nxt_amp_en;
    logic [2:0] gain_ff;
    logic [2:0] nxt_gain;
    logic [1:0] bias_ff;
    logic [1:0] nxt_bias;

    logic [31:0] result_ff;
    logic [31:0] nxt_result;
    logic [15:0] sample_ff;
    logic [15:0] nxt_sample;
    logic [23:0] acc_ff;
    logic [23:0] nxt_acc;
    logic [10:0] cnt_ff;
    logic [10:0] nxt_cnt;
    adc_fmt_pkg::acc_state_type state_ff;
    adc_fmt_pkg::acc_state_type nxt_state;
    logic sready_ff;
    logic nxt_sready;
    logic rready_ff;
    logic nxt_rready;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;
    adc_fmt_pkg::analog_ctl_type ctl_ff;
    adc_fmt_pkg::analog_ctl_type nxt_ctl;

    logic [11:0] conv_clipped;
    logic [23:0] acc_sum;
    logic [15:0] fmt_sample;
    logic [31:0] fmt_single;
    logic [31:0] fmt_accum;
    logic accum_mode;
    logic last_sample;
    logic restart;

    function automatic logic is_accum(input logic [2:0] m);
        is_accum = (m >= adc_fmt_pkg::MODE_SERIES) && (m <= adc_fmt_pkg::MODE_BURST_SCALED);
    endfunction : is_accum

    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs, input logic s);
        hit = s && (a == ofs);
    endfunction : hit

    adc_clock_divider divider (
        .core_clk(core_clk),
        .reset(reset),
        .clock_divider_sel(div_sel_ff),
        .clk_adc(clk_adc)
    );

    adc_result_formatter formatter (
        .mode(mode_ff),
        .left_align(left_ff),
        .differential_sel(differential_sel_ff),
        .accum_count_sel(acc_sel_ff),
        .conv(conv_clipped),
        .accum(nxt_acc),
        .sample_word(fmt_sample),
        .single_word(fmt_single),
        .accum_word(fmt_accum)
    );

    // control registers
    always_comb
    begin
        nxt_div_sel = div_sel_ff;
        nxt_ref_sel = ref_sel_ff;
        nxt_timebase = timebase_ff;
        nxt_mode = mode_ff;
        nxt_differential_sel = differential_sel_ff;
        nxt_acc_sel = acc_sel_ff;
        nxt_left = left_ff;
        nxt_run = run_ff;
        nxt_pos = pos_ff;
        nxt_neg = neg_ff;
        nxt_via = via_ff;
        nxt_amp_en = amp_en_ff;
        nxt_gain = gain_ff;
        nxt_bias = bias_ff;
        if (hit(addr, adc_fmt_pkg::OFS_CONTROL_TWO, wr))
        begin
            nxt_div_sel = wdata[adc_fmt_pkg::DIV_SEL_LSB +: 3];
        end
        if (hit(addr, adc_fmt_pkg::OFS_CONTROL_THREE, wr))
        begin
            nxt_ref_sel = wdata[adc_fmt_pkg::REF_SEL_LSB +: 3];
            nxt_timebase = wdata[adc_fmt_pkg::TIMEBASE_LSB +: 8];
        end
        if (hit(addr, adc_fmt_pkg::OFS_COMMAND, wr))
        begin
            // codes 6 and 7 are refused; the mode stays as it was
            if (wdata[adc_fmt_pkg::MODE_LSB +: 3] <= adc_fmt_pkg::MODE_BURST_SCALED)
            begin
                nxt_mode = wdata[adc_fmt_pkg::MODE_LSB +: 3];
            end
            nxt_differential_sel = wdata[adc_fmt_pkg::DIFFERENTIAL_SEL_BIT];
        end
        if (hit(addr, adc_fmt_pkg::OFS_CONTROL_F, wr))
        begin
            nxt_acc_sel = wdata[adc_fmt_pkg::ACC_SEL_LSB +: 4];
            if (nxt_acc_sel > adc_fmt_pkg::ACC_SEL_MAX)
            begin
                nxt_acc_sel = adc_fmt_pkg::ACC_SEL_MAX;
            end
            nxt_left = wdata[adc_fmt_pkg::LEFT_BIT];
            nxt_run = wdata[adc_fmt_pkg::RUN_BIT];
        end
        if (hit(addr, adc_fmt_pkg::OFS_POS_INPUT, wr))
        begin
            nxt_pos = wdata[adc_fmt_pkg::INPUT_LSB +: 6];
            nxt_via = wdata[adc_fmt_pkg::VIA_LSB +: 2];
        end
        if (hit(addr, adc_fmt_pkg::OFS_NEG_INPUT, wr))
        begin
            nxt_neg = wdata[adc_fmt_pkg::INPUT_LSB +: 6];
            nxt_via = wdata[adc_fmt_pkg::VIA_LSB +: 2];
        end
        if (hit(addr, adc_fmt_pkg::OFS_AMP_CONTROL, wr))
        begin
            nxt_amp_en = wdata[adc_fmt_pkg::AMP_EN_BIT];
            nxt_gain = wdata[adc_fmt_pkg::GAIN_LSB +: 3];
            if (nxt_gain > adc_fmt_pkg::GAIN_MAX)
            begin
                nxt_gain = adc_fmt_pkg::GAIN_MAX;
            end
            nxt_bias = wdata[adc_fmt_pkg::BIAS_LSB +: 2];
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            div_sel_ff <= adc_fmt_pkg::DIV_SEL_RESET;
            ref_sel_ff <= adc_fmt_pkg::REF_SEL_RESET;
            timebase_ff <= adc_fmt_pkg::TIMEBASE_RESET;
            mode_ff <= adc_fmt_pkg::MODE_RESET;
            differential_sel_ff <= 1'b0;
            acc_sel_ff <= adc_fmt_pkg::ACC_SEL_RESET;
            left_ff <= 1'b0;
            run_ff <= 1'b0;
            pos_ff <= adc_fmt_pkg::INPUT_RESET;
            neg_ff <= adc_fmt_pkg::INPUT_RESET;
            via_ff <= adc_fmt_pkg::VIA_RESET;
            amp_en_ff <= 1'b0;
            gain_ff <= adc_fmt_pkg::GAIN_RESET;
            bias_ff <= adc_fmt_pkg::BIAS_RESET;
        end
        else
        begin
            div_sel_ff <= nxt_div_sel;
            ref_sel_ff <= nxt_ref_sel;
            timebase_ff <= nxt_timebase;
            mode_ff <= nxt_mode;
            differential_sel_ff <= nxt_differential_sel;
            acc_sel_ff <= nxt_acc_sel;
            left_ff <= nxt_left;
            run_ff <= nxt_run;
            pos_ff <= nxt_pos;
            neg_ff <= nxt_neg;
            via_ff <= nxt_via;
            amp_en_ff <= nxt_amp_en;
            gain_ff <= nxt_gain;
            bias_ff <= nxt_bias;
        end
    end

    // accumulation and result capture
    always_comb
    begin
        accum_mode = is_accum(mode_ff);
        // any change of mode or count starts a fresh accumulation
        restart = hit(addr, adc_fmt_pkg::OFS_COMMAND, wr) || hit(addr, adc_fmt_pkg::OFS_CONTROL_F, wr);
        if (!differential_sel_ff && conv_in.over)
        begin
            conv_clipped = 12'hfff;
        end
        else if (!differential_sel_ff && conv_in.under)
        begin
            conv_clipped = 12'h000;
        end
        else
        begin
            conv_clipped = conv_in.data;
        end
        // idle means a fresh set: the previous finished sum is not added
        acc_sum = ((state_ff == adc_fmt_pkg::ACC_IDLE) ? 24'h000000 : acc_ff)
            + {{12{differential_sel_ff & conv_clipped[11]}}, conv_clipped};
        last_sample = (cnt_ff == 11'((12'h001 << acc_sel_ff) - 12'h001));
        nxt_state = state_ff;
        nxt_acc = acc_ff;
        nxt_cnt = cnt_ff;
        nxt_sample = sample_ff;
        nxt_result = result_ff;
        nxt_sready = 1'b0;
        nxt_rready = 1'b0;
        if (restart)
        begin
            nxt_state = adc_fmt_pkg::ACC_IDLE;
            nxt_acc = 24'h000000;
            nxt_cnt = 11'h000;
        end
        else if (conv_in.valid)
        begin
            nxt_sample = fmt_sample;
            nxt_sready = 1'b1;
            if (!accum_mode)
            begin
                nxt_result = fmt_single;
                nxt_rready = 1'b1;
            end
            else
            begin
                nxt_acc = acc_sum;
                if (last_sample)
                begin
                    // scaling seen by the formatter is applied to the final sum
                    nxt_result = fmt_accum;
                    nxt_rready = 1'b1;
                    nxt_state = adc_fmt_pkg::ACC_IDLE;
                    nxt_cnt = 11'h000;
                end
                else
                begin
                    nxt_state = adc_fmt_pkg::ACC_RUN;
                    nxt_cnt = cnt_ff + 11'h001;
                end
            end
        end
    end

    // a finished sum stays until the next set begins
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_ff <= adc_fmt_pkg::ACC_IDLE;
            acc_ff <= 24'h000000;
            cnt_ff <= 11'h000;
            sample_ff <= 16'h0000;
            result_ff <= 32'h00000000;
            sready_ff <= 1'b0;
            rready_ff <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            acc_ff <= nxt_acc;
            cnt_ff <= nxt_cnt;
            sample_ff <= nxt_sample;
            result_ff <= nxt_result;
            sready_ff <= nxt_sready;
            rready_ff <= nxt_rready;
        end
    end

    // analog settings and read port
    always_comb
    begin
        nxt_ctl.positive_input_sel = nxt_pos;
        nxt_ctl.negative_input_sel = nxt_differential_sel ? nxt_neg : adc_fmt_pkg::INPUT_RESET;
        nxt_ctl.negative_used = nxt_differential_sel;
        nxt_ctl.via_amp = nxt_via;
        nxt_ctl.reference_sel = nxt_ref_sel;
        nxt_ctl.amp_enable = nxt_amp_en;
        nxt_ctl.gain = nxt_gain;
        nxt_ctl.amp_bias_sel = nxt_bias;
        nxt_ctl.timebase = nxt_timebase;
        nxt_rdata = 32'h00000000;
        if (rd)
        begin
            unique case (addr)
                adc_fmt_pkg::OFS_CONTROL_TWO: nxt_rdata[adc_fmt_pkg::DIV_SEL_LSB +: 3] = div_sel_ff;
                adc_fmt_pkg::OFS_CONTROL_THREE:
                begin
                    nxt_rdata[adc_fmt_pkg::REF_SEL_LSB +: 3] = ref_sel_ff;
                    nxt_rdata[adc_fmt_pkg::TIMEBASE_LSB +: 8] = timebase_ff;
                end
                adc_fmt_pkg::OFS_COMMAND:
                begin
                    nxt_rdata[adc_fmt_pkg::MODE_LSB +: 3] = mode_ff;
                    nxt_rdata[adc_fmt_pkg::DIFFERENTIAL_SEL_BIT] = differential_sel_ff;
                end
                adc_fmt_pkg::OFS_CONTROL_F:
                begin
                    nxt_rdata[adc_fmt_pkg::ACC_SEL_LSB +: 4] = acc_sel_ff;
                    nxt_rdata[adc_fmt_pkg::LEFT_BIT] = left_ff;
                    nxt_rdata[adc_fmt_pkg::RUN_BIT] = run_ff;
                end
                adc_fmt_pkg::OFS_POS_INPUT:
                begin
                    nxt_rdata[adc_fmt_pkg::INPUT_LSB +: 6] = pos_ff;
                    nxt_rdata[adc_fmt_pkg::VIA_LSB +: 2] = via_ff;
                end
                adc_fmt_pkg::OFS_NEG_INPUT:
                begin
                    nxt_rdata[adc_fmt_pkg::INPUT_LSB +: 6] = neg_ff;
                    nxt_rdata[adc_fmt_pkg::VIA_LSB +: 2] = via_ff;
                end
                adc_fmt_pkg::OFS_AMP_CONTROL:
                begin
                    nxt_rdata[adc_fmt_pkg::AMP_EN_BIT] = amp_en_ff;
                    nxt_rdata[adc_fmt_pkg::GAIN_LSB +: 3] = gain_ff;
                    nxt_rdata[adc_fmt_pkg::BIAS_LSB +: 2] = bias_ff;
                end
                adc_fmt_pkg::OFS_CONVERSION_RESULT: nxt_rdata = result_ff;
                adc_fmt_pkg::OFS_LATEST_SAMPLE: nxt_rdata[15:0] = sample_ff;
                default: nxt_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rdata_ff <= 32'h00000000;
            ctl_ff <= '0;
            ctl_ff.timebase <= adc_fmt_pkg::TIMEBASE_RESET;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            ctl_ff <= nxt_ctl;
        end
    end

    assign rdata = rdata_ff;
    assign analog_ctl = ctl_ff;
    assign continuous_run = run_ff;
    assign sample_ready = sready_ff;
    assign result_ready = rready_ff;
endmodule : adc_result_control

/* File: core/adc_fmt_pkg.sv */
// shared constants, field layouts and carrier types for the converter control block
package adc_fmt_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CONTROL_TWO = 8'h00;
    localparam logic [7:0] OFS_CONTROL_THREE = 8'h04;
    localparam logic [7:0] OFS_COMMAND = 8'h08;
    localparam logic [7:0] OFS_CONTROL_F = 8'h0c;
    localparam logic [7:0] OFS_POS_INPUT = 8'h10;
    localparam logic [7:0] OFS_NEG_INPUT = 8'h14;
    localparam logic [7:0] OFS_AMP_CONTROL = 8'h18;
    localparam logic [7:0] OFS_CONVERSION_RESULT = 8'h1c;
    localparam logic [7:0] OFS_LATEST_SAMPLE = 8'h20;

    // field positions
    localparam int DIV_SEL_LSB = 0;
    localparam int REF_SEL_LSB = 0;
    localparam int TIMEBASE_LSB = 8;
    localparam int MODE_LSB = 0;
    localparam int DIFFERENTIAL_SEL_BIT = 5;
    localparam int ACC_SEL_LSB = 0;
    localparam int LEFT_BIT = 4;
    localparam int RUN_BIT = 5;
    localparam int INPUT_LSB = 0;
    localparam int VIA_LSB = 6;
    localparam int AMP_EN_BIT = 0;
    localparam int GAIN_LSB = 1;
    localparam int BIAS_LSB = 5;

    // reset values
    localparam logic [2:0] DIV_SEL_RESET = 3'h0;
    localparam logic [2:0] REF_SEL_RESET = 3'h0;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [3:0] ACC_SEL_RESET = 4'h0;
    localparam logic [5:0] INPUT_RESET = 6'h00;
    localparam logic [1:0] VIA_RESET = 2'h0;
    localparam logic [2:0] GAIN_RESET = 3'h0;
    localparam logic [1:0] BIAS_RESET = 2'h0;

    // gain codes 0..4 are 1x,2x,4x,8x,16x
    localparam logic [2:0] GAIN_MAX = 3'h4;
    localparam logic [3:0] ACC_SEL_MAX = 4'ha;
    localparam logic [3:0] SCALE_BASE = 4'h4;

    // timebase: one microsecond in core_clk cycles, rounded up
    localparam int CLK_PERIOD_PS = 8000;
    localparam int TIMEBASE_NS = 1;
    localparam int TIMEBASE_CYCLES = (TIMEBASE_NS * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0] TIMEBASE_RESET = TIMEBASE_CYCLES[7:0];

    typedef enum logic [2:0] {
        MODE_SINGLE8 = 3'h0,
        MODE_SINGLE12 = 3'h1,
        MODE_SERIES = 3'h2,
        MODE_SERIES_SCALED = 3'h3,
        MODE_BURST = 3'h4,
        MODE_BURST_SCALED = 3'h5
    } mode_type;

    typedef enum logic [0:0] {
        ACC_IDLE = 1'b0,
        ACC_RUN = 1'b1
    } acc_state_type;

    // one conversion delivered by the converter core
    typedef struct packed {
        logic valid;
        logic over;
        logic under;
        logic [11:0] data;
    } conv_in_type;

    // settings steering the analog side
    typedef struct packed {
        logic [5:0] positive_input_sel;
        logic [5:0] negative_input_sel;
        logic negative_used;
        logic [1:0] via_amp;
        logic [2:0] reference_sel;
        logic amp_enable;
        logic [2:0] gain;
        logic [1:0] amp_bias_sel;
        logic [7:0] timebase;
    } analog_ctl_type;

endpackage : adc_fmt_pkg

/* File: core/adc_clock_divider.sv */
// converter clock derived from core_clk by a power-of-two divider
module adc_clock_divider (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [2:0] clock_divider_sel,
    output logic clk_adc
);
    logic [7:0] cnt_ff;
    logic [7:0] nxt_cnt;
    logic clk_ff;
    logic nxt_clk;
    logic [7:0] half;

    // divide by 2^(sel+1): toggle every 2^sel cycles
    always_comb
    begin
        half = 8'h01 << clock_divider_sel;
        nxt_cnt = cnt_ff + 8'h01;
        nxt_clk = clk_ff;
        if (nxt_cnt >= half)
        begin
            nxt_cnt = 8'h00;
            nxt_clk = ~clk_ff;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_ff <= 8'h00;
            clk_ff <= 1'b0;
        end
        else
        begin
            cnt_ff <= nxt_cnt;
            clk_ff <= nxt_clk;
        end
    end

    assign clk_adc = clk_ff;
endmodule : adc_clock_divider

/* File: core/adc_result_formatter.sv */
// combinational formatting of sample, single and accumulated results
module adc_result_formatter (
    input wire logic [2:0] mode,
    input wire logic left_align,
    input wire logic differential_sel,
    input wire logic [3:0] accum_count_sel,
    input wire logic [11:0] conv,
    input wire logic [23:0] accum,
    output logic [15:0] sample_word,
    output logic [31:0] single_word,
    output logic [31:0] accum_word
);
    logic [15:0] scaled;
    logic signed [23:0] sacc;

    function automatic logic [15:0] ext12(input logic [11:0] v, input logic s);
        ext12 = {{4{s & v[11]}}, v};
    endfunction : ext12

    always_comb
    begin
        sacc = $signed(accum);
        if (mode == adc_fmt_pkg::MODE_SINGLE8)
        begin
            sample_word = {{8{differential_sel & conv[7]}}, conv[7:0]};
        end
        else if (left_align)
        begin
            sample_word = {conv, 4'h0};
        end
        else
        begin
            sample_word = ext12(conv, differential_sel);
        end
        single_word = {{16{differential_sel & sample_word[15]}}, sample_word};
        if (accum_count_sel >= adc_fmt_pkg::SCALE_BASE)
        begin
            scaled = 16'(sacc >>> (accum_count_sel - adc_fmt_pkg::SCALE_BASE));
        end
        else if (left_align)
        begin
            scaled = 16'(accum << (adc_fmt_pkg::SCALE_BASE - accum_count_sel));
        end
        else
        begin
            scaled = accum[15:0];
        end
        if (mode == adc_fmt_pkg::MODE_SERIES_SCALED || mode == adc_fmt_pkg::MODE_BURST_SCALED)
        begin
            accum_word = {{16{differential_sel & scaled[15]}}, scaled};
        end
        else
        begin
            // unscaled: left adjust ignored, full 24 bits kept
            accum_word = {{8{differential_sel & accum[23]}}, accum};
        end
    end
endmodule : adc_result_formatter

/* File: tb/adc_result_control_asserts.sv */
// concurrent checks on the converter control block ports
module adc_result_control_asserts (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    input wire logic [31:0] rdata,
    input wire adc_fmt_pkg::conv_in_type conv_in,
    input wire adc_fmt_pkg::analog_ctl_type analog_ctl,
    input wire logic continuous_run,
    input wire logic sample_ready,
    input wire logic result_ready,
    input wire logic clk_adc
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (reset);
    logic cfg_wr;
    // a mode or count write drops the sample of the same cycle
    assign cfg_wr = wr && (addr == adc_fmt_pkg::OFS_COMMAND || addr == adc_fmt_pkg::OFS_CONTROL_F);
    sample_taken_a: assert property (conv_in.valid && !cfg_wr |=> sample_ready)
        else $error("sample ready missing");
    ready_cause_a: assert property (sample_ready |-> $past(conv_in.valid))
        else $error("sample ready without conversion");
    result_pair_a: assert property (result_ready |-> sample_ready)
        else $error("result ready without sample");
    neg_unused_a: assert property (!analog_ctl.negative_used |-> analog_ctl.negative_input_sel == 6'h00)
        else $error("negative input driven single-ended");
    gain_range_a: assert property (analog_ctl.gain <= adc_fmt_pkg::GAIN_MAX)
        else $error("gain above 16x");
    amp_off_a: assert property ($fell(reset) |-> !analog_ctl.amp_enable)
        else $error("amplifier on after reset");
    via_shared_a: assert property (wr && (addr == adc_fmt_pkg::OFS_POS_INPUT
        || addr == adc_fmt_pkg::OFS_NEG_INPUT) |=> analog_ctl.via_amp == $past(wdata[7:6]))
        else $error("via routing not shared");
    ref_write_a: assert property (wr && addr == adc_fmt_pkg::OFS_CONTROL_THREE
        |=> analog_ctl.reference_sel == $past(wdata[2:0]))
        else $error("reference select not applied");
    pos_direct_a: assert property (wr && addr == adc_fmt_pkg::OFS_POS_INPUT
        |=> analog_ctl.positive_input_sel == $past(wdata[5:0]))
        else $error("positive input not applied");
    bias_write_a: assert property (wr && addr == adc_fmt_pkg::OFS_AMP_CONTROL
        |=> analog_ctl.amp_bias_sel == $past(wdata[6:5]) && analog_ctl.amp_enable == $past(wdata[0]))
        else $error("amplifier control not applied");
    cover property (result_ready && !sample_ready == 1'b0);
    cover property (wr && addr == adc_fmt_pkg::OFS_NEG_INPUT);
    cover property (analog_ctl.amp_enable && analog_ctl.gain == adc_fmt_pkg::GAIN_MAX);
endmodule : adc_result_control_asserts

bind adc_result_control adc_result_control_asserts adc_result_control_asserts_inst (
    .core_clk(core_clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .conv_in(conv_in), .analog_ctl(analog_ctl), .continuous_run(continuous_run),
    .sample_ready(sample_ready), .result_ready(result_ready), .clk_adc(clk_adc));

/* File: tb/testbench.sv */
// self-checking bench for the converter control block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk, reset, wr, rd, clk_adc, continuous_run, sample_ready, result_ready, rr;
    logic [7:0] addr;
    logic [31:0] wdata, rdata;
    adc_fmt_pkg::conv_in_type conv_in;
    adc_fmt_pkg::analog_ctl_type analog_ctl;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;
    adc_result_control adc_result_control_inst (.core_clk(core_clk), .reset(reset), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .conv_in(conv_in),
        .analog_ctl(analog_ctl), .continuous_run(continuous_run),
        .sample_ready(sample_ready), .result_ready(result_ready), .clk_adc(clk_adc));
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic conclude;
        $display("fails %0d n_tests %0d", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge core_clk);
        wr <= 1'b0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge core_clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge core_clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask : rreg
    task automatic conv(input logic [11:0] d, input logic ov, input logic un);
        @(posedge core_clk);
        conv_in <= '{1'b1, ov, un, d};
        @(posedge core_clk);
        conv_in.valid <= 1'b0;
        #1 chk(sample_ready, 1'b1);
        rr = result_ready;
    endtask : conv
    task automatic one(input logic [7:0] cmd, f, input logic [11:0] d, input logic ov, un,
        input logic [31:0] es, er);
        wreg(8'h08, {24'h0, cmd});
        wreg(8'h0c, {24'h0, f});
        conv(d, ov, un);
        chk(rr, 1'b1);
        rreg(8'h20, es);
        rreg(8'h1c, er);
    endtask : one
    task automatic acc(input logic [7:0] cmd, f, input logic [11:0] d, input int n,
        input logic [31:0] er);
        wreg(8'h08, {24'h0, cmd});
        wreg(8'h0c, {24'h0, f});
        // no result until the last sample of the set
        repeat (n - 1)
        begin
            conv(d, 1'b0, 1'b0);
            chk(rr, 1'b0);
        end
        conv(d, 1'b0, 1'b0);
        chk(rr, 1'b1);
        rreg(8'h1c, er);
    endtask : acc
    task automatic t_regs;
        rreg(8'h04, 32'h00007d00);
        rreg(8'h18, 32'h0);
        chk(analog_ctl.amp_enable, 1'b0);
        rreg(8'h40, 32'h0);
        wreg(8'h04, 32'h00000805);
        #1 chk(analog_ctl.reference_sel, 3'h5);
        chk(analog_ctl.timebase, 8'h08);
        $display("test regs done");
    endtask : t_regs
    task automatic t_single;
        one(8'h00, 8'h10, 12'h3a5, 1'b0, 1'b0, 32'h00a5, 32'h00a5);
        one(8'h20, 8'h10, 12'h085, 1'b0, 1'b0, 32'hff85, 32'hffffff85);
        one(8'h01, 8'h10, 12'habc, 1'b0, 1'b0, 32'habc0, 32'habc0);
        one(8'h21, 8'h10, 12'h800, 1'b0, 1'b0, 32'h8000, 32'hffff8000);
        one(8'h21, 8'h00, 12'h800, 1'b0, 1'b0, 32'hf800, 32'hfffff800);
        one(8'h01, 8'h00, 12'h123, 1'b1, 1'b0, 32'h0fff, 32'h0fff);
        one(8'h01, 8'h00, 12'h123, 1'b0, 1'b1, 32'h0000, 32'h0000);
        // reserved mode code keeps 12-bit mode
        one(8'h06, 8'h00, 12'habc, 1'b0, 1'b0, 32'h0abc, 32'h0abc);
        $display("test single done");
    endtask : t_single
    task automatic t_accum;
        acc(8'h02, 8'h11, 12'h100, 2, 32'h200);
        acc(8'h03, 8'h05, 12'h100, 32, 32'h1000);
        acc(8'h03, 8'h12, 12'h123, 4, 32'h1230);
        acc(8'h24, 8'h01, 12'hfff, 2, 32'hfffffffe);
        acc(8'h25, 8'h10, 12'hfff, 1, 32'hfffffff0);
        $display("test accum done");
    endtask : t_accum
    task automatic t_analog;
        wreg(8'h08, 32'h01);
        wreg(8'h10, 32'hc5);
        rreg(8'h14, 32'hc0);
        chk(analog_ctl.positive_input_sel, 6'h05);
        wreg(8'h14, 32'h47);
        rreg(8'h10, 32'h45);
        chk(analog_ctl.negative_input_sel, 6'h00);
        wreg(8'h08, 32'h21);
        #1 chk(analog_ctl.negative_input_sel, 6'h07);
        wreg(8'h18, 32'h7f);
        rreg(8'h18, 32'h69);
        chk(analog_ctl.gain, 3'h4);
        wreg(8'h0c, 32'h2f);
        #1 chk(continuous_run, 1'b1);
        // counts above ten clamp to ten
        rreg(8'h0c, 32'h2a);
        $display("test analog done");
    endtask : t_analog
    task automatic t_clock(input logic [2:0] sel, input int exp);
        int n;
        logic prev;
        n = 0;
        wreg(8'h00, {29'h0, sel});
        repeat (8) @(posedge core_clk);
        #1 prev = clk_adc;
        repeat (32)
        begin
            @(posedge core_clk);
            #1 if (clk_adc && !prev) n++;
            prev = clk_adc;
        end
        chk(n, exp);
        $display("test clock done");
    endtask : t_clock
    always @(posedge core_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 5000)
        begin
            fails++;
            conclude;
        end
    end
    initial
    begin
        reset = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        conv_in = '0;
        repeat (4) @(posedge core_clk);
        reset <= 1'b0;
        t_regs;
        t_single;
        t_accum;
        t_analog;
        t_clock(3'h0, 16);
        t_clock(3'h2, 4);
        conclude;
    end
endmodule : testbench
